//--- fault_monitor_pkg.sv
/*
 * Package for the positioner fault monitor: register offsets, field layouts,
 * reset values, fault codes and timing counts.
 * Assumes a 32-bit APB master and a 40 MHz system clock.
 */
package fault_monitor_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_STROKE_LIMIT = 8'h04;
    localparam logic [7:0] OFS_DIRCHG_LIMIT = 8'h08;
    localparam logic [7:0] OFS_BOTTOM_TOL = 8'h0C;
    localparam logic [7:0] OFS_TOP_TOL = 8'h10;
    localparam logic [7:0] OFS_DEADZONE_LIMIT = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_CODE = 8'h1C;

    // control field positions
    localparam int CTL_FAULT_DI = 0;
    localparam int CTL_IN1_FUNC = 1;
    localparam int CTL_IN2_FUNC = 2;
    localparam int CTL_CLOSE_BOTTOM = 3;
    localparam int CTL_CLOSE_TOP = 4;
    localparam int CTL_DEADBAND_AUTO = 5;

    // reset values; zero in a limit or tolerance means off
    localparam logic [31:0] RST_CONTROL = 32'h0000_0000;
    localparam logic [31:0] RST_LIMIT = 32'h0000_0000;
    localparam logic [15:0] LIMIT_OFF = 16'h0000;

    // fault codes, shown in turn
    localparam logic [3:0] CODE_NONE = 4'h0;
    localparam logic [3:0] CODE_DIGITAL = 4'h3;
    localparam logic [3:0] CODE_STROKE = 4'h4;
    localparam logic [3:0] CODE_DIRCHG = 4'h5;
    localparam logic [3:0] CODE_BOTTOM = 4'h6;
    localparam logic [3:0] CODE_TOP = 4'h7;
    localparam logic [3:0] CODE_DEADZONE = 4'h8;
    localparam int NUM_FAULTS = 6;

    // dwell time of each code in the cycling display
    localparam int CLK_HZ = 40_000_000;
    localparam int CODE_DWELL_MS = 1000;
    localparam int CODE_DWELL_CYC = CLK_HZ / 1000 * CODE_DWELL_MS;

    typedef struct packed {
        logic [31:0] stroke_total;
        logic [31:0] direction_changes;
        logic [15:0] dead_zone;
        logic signed [15:0] position;
        logic signed [15:0] bottom_stop;
        logic signed [15:0] top_stop;
    } measure_t;

    typedef struct packed {
        logic input1;
        logic input2;
        logic sealed_bottom;
        logic sealed_top;
        logic init_done;
    } event_t;

endpackage

//--- positioner_fault_monitor.sv
/*
 * Fault monitor of a valve positioner: checks digital inputs, counter
 * limits, hard stop deviations at sealing and the adapted dead zone,
 * and drives one fault output plus a cycling fault code.
 * Assumes measurements and events are synchronous to CLK_SYS_I and that
 * seal and init events are one-cycle pulses from the control core.
 */
// What this block does
// - fault on input 1 active when fault output and input1 function select it
// - same configurable fault for input 2 when alarm module fitted
// - compare stroke total and direction changes with limits continuously
// - fault when stroke total or direction changes exceed limit
// - each counter comparison disabled by its off limit
// - bottom stop monitoring only while tolerance is not off
// - hard stop check happens at each sealing event only
// - check compares position with bottom stop captured at initialization
// - bottom check needs tight closing at bottom selected
// - fault when deviation beyond tolerance, positive or negative
// - stop fault latched until a good check or new initialization
// - tolerance set to off clears latched stop fault at once
// - same check with own tolerance at the top stop
// - top check needs tight closing at top selected
// - with automatic dead zone, fault when dead zone exceeds limit
// - several active faults shown one after another, repeating
`timescale 1ns/1ps

module positioner_fault_monitor #(
    parameter bit ALARM_MODULE = 1'b1,
    parameter int DWELL_CYCLES = fault_monitor_pkg::CODE_DWELL_CYC
) (
    // clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RESET_N_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // measurements and events
    input wire fault_monitor_pkg::measure_t MEASURE_I,
    input wire fault_monitor_pkg::event_t EVENT_I,
    // fault message
    output logic FAULT_O,
    output logic [3:0] FAULT_CODE_O
);

    localparam int NUM_W = 3;

    logic [31:0] control;
    logic [31:0] stroke_limit;
    logic [31:0] direction_change_limit;
    logic [15:0] bottom_tol;
    logic [15:0] top_tol;
    logic [15:0] dead_zone_limit;
    logic signed [15:0] bottom_ref;
    logic signed [15:0] top_ref;
    logic bottom_fault;
    logic top_fault;
    logic [NUM_W-1:0] show_idx;
    logic [31:0] dwell;
    logic [31:0] rdata;

    // absolute deviation beyond tolerance
    function automatic logic outside(input logic signed [15:0] pos,
                                     input logic signed [15:0] ref_pos,
                                     input logic [15:0] tol);
        logic signed [16:0] diff;
        diff = 17'(pos) - 17'(ref_pos);
        outside = (diff > $signed({1'b0, tol})) || (diff < -$signed({1'b0, tol}));
    endfunction

    wire apb_access = PSEL_I && PENABLE_I;
    wire apb_write = apb_access && PWRITE_I;
    wire addr_ok = (PADDR_I[1:0] == 2'b00) && (PADDR_I <= fault_monitor_pkg::OFS_CODE);

    wire fault_di_sel = control[fault_monitor_pkg::CTL_FAULT_DI];
    wire close_bottom = control[fault_monitor_pkg::CTL_CLOSE_BOTTOM];
    wire close_top = control[fault_monitor_pkg::CTL_CLOSE_TOP];
    wire dead_band_auto = control[fault_monitor_pkg::CTL_DEADBAND_AUTO];

    wire in1_fault = fault_di_sel && control[fault_monitor_pkg::CTL_IN1_FUNC]
        && EVENT_I.input1;
    wire in2_fault = ALARM_MODULE && fault_di_sel && control[fault_monitor_pkg::CTL_IN2_FUNC]
        && EVENT_I.input2;
    wire stroke_fault = (stroke_limit != 32'h0000_0000)
        && (MEASURE_I.stroke_total > stroke_limit);
    wire dirchg_fault = (direction_change_limit != 32'h0000_0000)
        && (MEASURE_I.direction_changes > direction_change_limit);
    wire bottom_on = (bottom_tol != fault_monitor_pkg::LIMIT_OFF) && close_bottom;
    wire top_on = (top_tol != fault_monitor_pkg::LIMIT_OFF) && close_top;
    wire bottom_bad = outside(MEASURE_I.position, bottom_ref, bottom_tol);
    wire top_bad = outside(MEASURE_I.position, top_ref, top_tol);
    wire deadzone_fault = dead_band_auto && (dead_zone_limit != fault_monitor_pkg::LIMIT_OFF)
        && (MEASURE_I.dead_zone > dead_zone_limit);

    wire [fault_monitor_pkg::NUM_FAULTS-1:0] active = {deadzone_fault, top_fault, bottom_fault,
        dirchg_fault, stroke_fault, in1_fault || in2_fault};

    // reference stops are caught at initialization
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESET_N_I) begin
            bottom_ref <= 16'sh0000;
            top_ref <= 16'sh0000;
        end else if (EVENT_I.init_done) begin
            bottom_ref <= MEASURE_I.bottom_stop;
            top_ref <= MEASURE_I.top_stop;
        end
    end

    // stop faults: evaluated only at sealing, held until an init or a switch-off clears them
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESET_N_I) begin
            bottom_fault <= 1'b0;
        end else if (!bottom_on) begin
            bottom_fault <= 1'b0;
        end else if (EVENT_I.sealed_bottom) begin
            // a check in the same cycle as an init clear wins
            bottom_fault <= bottom_bad;
        end else if (EVENT_I.init_done) begin
            bottom_fault <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (!RESET_N_I) begin
            top_fault <= 1'b0;
        end else if (!top_on) begin
            top_fault <= 1'b0;
        end else if (EVENT_I.sealed_top) begin
            top_fault <= top_bad;
        end else if (EVENT_I.init_done) begin
            top_fault <= 1'b0;
        end
    end

    // registers
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESET_N_I) begin
            control <= fault_monitor_pkg::RST_CONTROL;
            stroke_limit <= fault_monitor_pkg::RST_LIMIT;
            direction_change_limit <= fault_monitor_pkg::RST_LIMIT;
            bottom_tol <= fault_monitor_pkg::RST_LIMIT[15:0];
            top_tol <= fault_monitor_pkg::RST_LIMIT[15:0];
            dead_zone_limit <= fault_monitor_pkg::RST_LIMIT[15:0];
        end else if (apb_write) begin
            unique case (PADDR_I)
                fault_monitor_pkg::OFS_CONTROL: control <= {26'h0, PWDATA_I[5:0]};
                fault_monitor_pkg::OFS_STROKE_LIMIT: stroke_limit <= PWDATA_I;
                fault_monitor_pkg::OFS_DIRCHG_LIMIT: direction_change_limit <= PWDATA_I;
                fault_monitor_pkg::OFS_BOTTOM_TOL: bottom_tol <= PWDATA_I[15:0];
                fault_monitor_pkg::OFS_TOP_TOL: top_tol <= PWDATA_I[15:0];
                fault_monitor_pkg::OFS_DEADZONE_LIMIT: dead_zone_limit <= PWDATA_I[15:0];
                default: ;
            endcase
        end
    end

    // a one-second dwell keeps each code readable on the display
    wire [NUM_W-1:0] next_show_idx = (show_idx == NUM_W'(fault_monitor_pkg::NUM_FAULTS - 1))
        ? '0 : show_idx + 1'b1;
    wire dwell_done = (dwell >= 32'(DWELL_CYCLES - 1));

    always_ff @(posedge CLK_SYS_I) begin
        if (!RESET_N_I) begin
            show_idx <= '0;
            dwell <= 32'h0000_0000;
        end else if (!active[show_idx] || dwell_done) begin
            show_idx <= next_show_idx;
            dwell <= 32'h0000_0000;
        end else begin
            dwell <= dwell + 32'h0000_0001;
        end
    end

    function automatic logic [3:0] code_of(input logic [NUM_W-1:0] idx);
        unique case (idx)
            3'd0: code_of = fault_monitor_pkg::CODE_DIGITAL;
            3'd1: code_of = fault_monitor_pkg::CODE_STROKE;
            3'd2: code_of = fault_monitor_pkg::CODE_DIRCHG;
            3'd3: code_of = fault_monitor_pkg::CODE_BOTTOM;
            3'd4: code_of = fault_monitor_pkg::CODE_TOP;
            default: code_of = fault_monitor_pkg::CODE_DEADZONE;
        endcase
    endfunction

    always_ff @(posedge CLK_SYS_I) begin
        if (!RESET_N_I) begin
            FAULT_O <= 1'b0;
            FAULT_CODE_O <= fault_monitor_pkg::CODE_NONE;
        end else begin
            FAULT_O <= |active;
            FAULT_CODE_O <= active[show_idx] ? code_of(show_idx)
                : fault_monitor_pkg::CODE_NONE;
        end
    end

    always_comb begin
        rdata = 32'h0000_0000;
        unique case (PADDR_I)
            fault_monitor_pkg::OFS_CONTROL: rdata = control;
            fault_monitor_pkg::OFS_STROKE_LIMIT: rdata = stroke_limit;
            fault_monitor_pkg::OFS_DIRCHG_LIMIT: rdata = direction_change_limit;
            fault_monitor_pkg::OFS_BOTTOM_TOL: rdata = {16'h0, bottom_tol};
            fault_monitor_pkg::OFS_TOP_TOL: rdata = {16'h0, top_tol};
            fault_monitor_pkg::OFS_DEADZONE_LIMIT: rdata = {16'h0, dead_zone_limit};
            fault_monitor_pkg::OFS_STATUS: rdata = {25'h0, FAULT_O, active};
            fault_monitor_pkg::OFS_CODE: rdata = {28'h0, FAULT_CODE_O};
            default: rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (!RESET_N_I) begin
            PRDATA_O <= 32'h0000_0000;
        end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
            PRDATA_O <= rdata;
        end
    end

    assign PREADY_O = 1'b1;
    assign PSLVERR_O = apb_access && !addr_ok;

endmodule // positioner_fault_monitor

//--- positioner_fault_monitor_sva.sv
/* Checker for positioner_fault_monitor: shadows configuration writes and the
   stop references, then ties the fault output to its causes.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps
module positioner_fault_monitor_sva #(parameter bit ALARM_MODULE = 1'b1) (
    // clock, reset and apb
    input wire logic CLK_SYS_I, RESET_N_I, PSEL_I, PENABLE_I, PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I, PRDATA_O,
    input wire logic PREADY_O, PSLVERR_O,
    // measurements, events and fault message
    input wire fault_monitor_pkg::measure_t MEASURE_I,
    input wire fault_monitor_pkg::event_t EVENT_I,
    input wire logic FAULT_O,
    input wire logic [3:0] FAULT_CODE_O
);
    logic [31:0] cfg [6];
    logic signed [15:0] bref, tref;
    wire wr = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O;
    wire [31:0] ctl = cfg[0];
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESET_N_I) begin
            cfg <= '{default: '0};
            bref <= '0;
            tref <= '0;
        end else begin
            if (wr && PADDR_I < 8'h18 && PADDR_I[1:0] == 2'b00) begin
                cfg[PADDR_I[4:2]] <= PWDATA_I;
            end
            if (EVENT_I.init_done) begin
                bref <= MEASURE_I.bottom_stop;
                tref <= MEASURE_I.top_stop;
            end
        end
    end
    function automatic logic over(input logic signed [15:0] p, r, input logic [31:0] t);
        int d;
        d = p - r;
        return d > int'(t[15:0]) || d < -int'(t[15:0]);
    endfunction
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RESET_N_I);
    AST_DIG1: assert property (ctl[0] && ctl[1] && EVENT_I.input1 |=> FAULT_O)
        else $error("input 1 fault missing");
    AST_DIG2: assert property (ALARM_MODULE && ctl[0] && ctl[2] && EVENT_I.input2
        |=> FAULT_O)
        else $error("input 2 fault missing");
    AST_STROKE: assert property (cfg[1] != 0 && MEASURE_I.stroke_total > cfg[1]
        |=> FAULT_O)
        else $error("stroke fault missing");
    AST_DIRCHG: assert property (cfg[2] != 0 && MEASURE_I.direction_changes > cfg[2]
        |=> FAULT_O)
        else $error("direction change fault missing");
    AST_DEADZONE: assert property (ctl[5] && cfg[5][15:0] != 0
        && MEASURE_I.dead_zone > cfg[5][15:0] |=> FAULT_O)
        else $error("dead zone fault missing");
    AST_BOTTOM: assert property (EVENT_I.sealed_bottom && ctl[3] && cfg[3][15:0] != 0
        && over(MEASURE_I.position, bref, cfg[3]) |-> ##2 FAULT_O)
        else $error("bottom stop fault missing");
    AST_TOP: assert property (EVENT_I.sealed_top && ctl[4] && cfg[4][15:0] != 0
        && over(MEASURE_I.position, tref, cfg[4]) |-> ##2 FAULT_O)
        else $error("top stop fault missing");
    AST_ALL_OFF: assert property ((ctl[5:0] == 6'h00 && cfg[1] == 0 && cfg[2] == 0) [*2]
        |=> !FAULT_O)
        else $error("fault with every check off");
    AST_CODE: assert property (FAULT_CODE_O != fault_monitor_pkg::CODE_NONE |-> FAULT_O)
        else $error("fault code shown without fault");
    cover property (EVENT_I.sealed_bottom && ctl[3]);
    cover property (FAULT_O && FAULT_CODE_O == fault_monitor_pkg::CODE_TOP);
    cover property ($rose(FAULT_O));
endmodule // positioner_fault_monitor_sva

//--- test_positioner_fault_monitor.sv
/* Self-checking bench for positioner_fault_monitor with a behavioural model.
   Assumes zero-wait APB and a dwell of 8 cycles per shown code. */
`timescale 1ns/1ps
module test_positioner_fault_monitor;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, pslverr, fault;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic [3:0] code;
    fault_monitor_pkg::measure_t meas = '0;
    fault_monitor_pkg::event_t ev = '0;
    int error_cnt = 0, cmp_count = 0, seed = 96, bref = 0, tref = 0, bflt = 0, tflt = 0;
    int cfg [6] = '{default: 0};
    always #12.5 clk = ~clk;
    positioner_fault_monitor #(.DWELL_CYCLES(8)) u_dut (
        .CLK_SYS_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .MEASURE_I(meas), .EVENT_I(ev), .FAULT_O(fault),
        .FAULT_CODE_O(code));
    task automatic stop_test();
        $display("compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // model: status word {fault, dz, top, bottom, dirchg, stroke, digital}
    function automatic logic [31:0] status();
        logic [5:0] a;
        a[0] = cfg[0][0] && ((cfg[0][1] && ev.input1) || (cfg[0][2] && ev.input2));
        a[1] = cfg[1] != 0 && meas.stroke_total > cfg[1];
        a[2] = cfg[2] != 0 && meas.direction_changes > cfg[2];
        a[3] = bflt != 0;
        a[4] = tflt != 0;
        a[5] = cfg[0][5] && cfg[5] != 0 && meas.dead_zone > cfg[5];
        return {25'h0, |a, a};
    endfunction
    task automatic wr(input logic [7:0] a, input int d);
        logic [31:0] rd;
        logic er;
        apb(1'b1, a, d, rd, er);
        if (a < 8'h18) cfg[a >> 2] = d;
        if (cfg[3] == 0 || !cfg[0][3]) bflt = 0;
        if (cfg[4] == 0 || !cfg[0][4]) tflt = 0;
        apb(1'b0, a, '0, rd, er);
        if (a < 8'h18) chk(rd, d);
    endtask
    task automatic settle();
        logic [31:0] rd, s;
        logic er;
        repeat (3) @(posedge clk);
        s = status();
        chk(fault, s[6]);
        apb(1'b0, fault_monitor_pkg::OFS_STATUS, '0, rd, er);
        chk(rd, status());
    endtask
    task automatic seal(input int t, input int pos);
        int dv;
        dv = pos - (t != 0 ? tref : bref);
        @(posedge clk);
        meas.position <= 16'(pos);
        ev.sealed_top <= t != 0;
        ev.sealed_bottom <= t == 0;
        @(posedge clk);
        ev.sealed_top <= 1'b0;
        ev.sealed_bottom <= 1'b0;
        if (cfg[3 + t] != 0 && cfg[0][3 + t]) begin
            if (t != 0) tflt = dv > cfg[4] || dv < -cfg[4];
            else bflt = dv > cfg[3] || dv < -cfg[3];
        end
    endtask
    task automatic init_pulse();
        @(posedge clk);
        ev.init_done <= 1'b1;
        @(posedge clk);
        ev.init_done <= 1'b0;
        bref = 200;
        tref = 900;
        bflt = 0;
        tflt = 0;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        stop_test();
    end
    initial begin
        logic [31:0] rd, seen;
        logic er;
        int v, r;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 36; a += 4) begin
            apb(1'b0, 8'(a), '0, rd, er);
            chk(rd, 0);
            chk(er, a > 28);
        end
        v = ($random(seed) & 32'hFFF) + 2;
        meas.stroke_total <= v;
        meas.direction_changes <= v;
        meas.dead_zone <= 16'(v);
        for (int i = 1; i < 3; i++) begin
            wr(8'(4 * i), v);
            settle();
            wr(8'(4 * i), v - 1);
            settle();
            wr(8'(4 * i), 0);
            settle();
        end
        wr(fault_monitor_pkg::OFS_CONTROL, 32'h20);
        wr(fault_monitor_pkg::OFS_DEADZONE_LIMIT, v - 1);
        settle();
        ev.input1 <= 1'b1;
        wr(fault_monitor_pkg::OFS_CONTROL, 3);
        settle();
        wr(fault_monitor_pkg::OFS_CONTROL, 2);
        settle();
        ev.input1 <= 1'b0;
        ev.input2 <= 1'b1;
        wr(fault_monitor_pkg::OFS_CONTROL, 5);
        wr(fault_monitor_pkg::OFS_STROKE_LIMIT, v - 1);
        wr(fault_monitor_pkg::OFS_STATUS, 32'hFF);
        settle();
        seen = '0;
        repeat (40) @(posedge clk) seen[code] = 1'b1;
        chk(seen & ~32'h1, (32'h1 << fault_monitor_pkg::CODE_DIGITAL)
            | (32'h1 << fault_monitor_pkg::CODE_STROKE));
        ev.input2 <= 1'b0;
        wr(fault_monitor_pkg::OFS_STROKE_LIMIT, 0);
        meas.bottom_stop <= 16'sd200;
        meas.top_stop <= 16'sd900;
        init_pulse();
        wr(fault_monitor_pkg::OFS_CONTROL, 32'h18);
        for (int t = 0; t < 2; t++) begin
            r = t != 0 ? 900 : 200;
            wr(8'(12 + 4 * t), 3);
            seal(t, r + 3);
            settle();
            seal(t, r - 4);
            settle();
            seal(t, r);
            meas.position <= 16'(r + 9);
            settle();
            seal(t, r + 4);
            settle();
            wr(8'(12 + 4 * t), 0);
            settle();
            seal(t, r + 4);
            settle();
            wr(8'(12 + 4 * t), 3);
            seal(t, r + 4);
            init_pulse();
            settle();
        end
        wr(fault_monitor_pkg::OFS_CONTROL, 32'h10);
        seal(0, 290);
        seal(1, 990);
        settle();
        wr(fault_monitor_pkg::OFS_CONTROL, 32'h08);
        seal(1, 990);
        settle();
        stop_test();
    end
endmodule // test_positioner_fault_monitor
bind positioner_fault_monitor positioner_fault_monitor_sva #(.ALARM_MODULE(ALARM_MODULE)) u_sva (
    .CLK_SYS_I(CLK_SYS_I), .RESET_N_I(RESET_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .MEASURE_I(MEASURE_I), .EVENT_I(EVENT_I),
    .FAULT_O(FAULT_O), .FAULT_CODE_O(FAULT_CODE_O));
